// File: logic/inclusive_or_ops.sv
`timescale 1ns/100ps
// Behaviour
// - Opcode 111000 ORs literal into accumulator
// - Immediate result always to accumulator only
// - Opcode 000100, destination bit, 7-bit address
// - Destination zero writes accumulator only
// - Destination one writes file register only
module inclusive_or_ops (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // From decoder, held for the whole cycle
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  // File register read data
  input wire logic [7:0] file_rdata,
  // Phase and file register access
  output logic [1:0] phase,
  output logic file_rd,
  output logic [6:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  // Accumulator and zero flag
  output logic [7:0] acc,
  output logic zero_we,
  output logic zero_flag,
  output logic done
);
  // Phase counter
  or_ops_pkg::phase_e ph;
  or_ops_pkg::phase_e next_ph;
  logic [1:0] next_phase;

  // Operand and accumulator
  logic [7:0] operand;
  logic [7:0] next_operand;
  logic [7:0] next_acc;
  logic [7:0] or_value;

  // Instruction kind, caught at decode
  logic active;
  logic next_active;
  logic kind_imm;
  logic next_kind_imm;
  logic kind_file;
  logic next_kind_file;
  logic to_file;
  logic next_to_file;

  // File register access
  logic next_file_rd;
  logic [6:0] next_file_addr;
  logic next_file_we;
  logic [7:0] next_file_wdata;

  // Status and completion
  logic next_zero_we;
  logic next_zero_flag;
  logic next_done;

  // Decoder outputs
  logic is_imm;
  logic is_file;
  logic dest_file;
  logic [7:0] literal;
  logic [6:0] dec_addr;

  // Shared by both instructions and both destinations
  function automatic logic [7:0] or_result(
    input logic [7:0] a,
    input logic [7:0] b
  );
    return a | b;
  endfunction

  // Zero test behind the status flag
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  or_decode u_dec (
    .instr(instr),
    .is_imm(is_imm),
    .is_file(is_file),
    .dest_file(dest_file),
    .literal(literal),
    .file_addr(dec_addr)
  );

  always_comb begin
    next_ph = ph;
    next_operand = operand;
    next_acc = acc;
    next_active = active;
    next_kind_imm = kind_imm;
    next_kind_file = kind_file;
    next_to_file = to_file;
    next_file_rd = 1'b0;
    next_file_addr = file_addr;
    next_file_we = 1'b0;
    next_file_wdata = file_wdata;
    next_zero_we = 1'b0;
    next_zero_flag = zero_flag;
    next_done = 1'b0;
    or_value = or_result(acc, operand);
    unique case (ph)
      or_ops_pkg::PH_DECODE: begin
        next_ph = or_ops_pkg::PH_READ;
        // Kind is caught once, so a decoder that moves on
        // early cannot turn one instruction into another
        next_active = instr_valid && (is_imm || is_file);
        next_kind_imm = instr_valid && is_imm;
        next_kind_file = instr_valid && is_file;
        next_to_file = instr_valid && is_file && dest_file;
        next_file_addr = dec_addr;
        // Read strobe lands in Q2 so data is present there
        next_file_rd = instr_valid && is_file;
      end
      or_ops_pkg::PH_READ: begin
        next_ph = or_ops_pkg::PH_PROCESS;
        // Literal is taken live, so instr must hold through Q2
        if (kind_imm) begin
          next_operand = literal;
        end else if (kind_file) begin
          next_operand = file_rdata;
        end
      end
      or_ops_pkg::PH_PROCESS: begin
        next_ph = or_ops_pkg::PH_WRITE;
        if (active) begin
          next_zero_we = 1'b1;
          next_zero_flag = is_zero(or_value);
          next_done = 1'b1;
          if (to_file) begin
            next_file_we = 1'b1;
            next_file_wdata = or_value;
          end else begin
            // Literal form can only land here
            next_acc = or_value;
          end
        end
      end
      or_ops_pkg::PH_WRITE: begin
        next_ph = or_ops_pkg::PH_DECODE;
        // No kind or destination flag survives into the next instruction
        next_active = 1'b0;
        next_kind_imm = 1'b0;
        next_kind_file = 1'b0;
        next_to_file = 1'b0;
      end
    endcase
    next_phase = 2'(next_ph);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // Phase and instruction kind
      ph <= or_ops_pkg::PH_DECODE;
      phase <= or_ops_pkg::PHASE_RESET;
      active <= 1'b0;
      kind_imm <= 1'b0;
      kind_file <= 1'b0;
      to_file <= 1'b0;
      // Datapath
      operand <= or_ops_pkg::ACC_RESET;
      acc <= or_ops_pkg::ACC_RESET;
      file_rd <= 1'b0;
      file_addr <= 7'h00;
      file_we <= 1'b0;
      file_wdata <= or_ops_pkg::ACC_RESET;
      // Status
      zero_we <= 1'b0;
      zero_flag <= 1'b0;
      done <= 1'b0;
    end else begin
      ph <= next_ph;
      phase <= next_phase;
      kind_imm <= next_kind_imm;
      kind_file <= next_kind_file;
      to_file <= next_to_file;
      operand <= next_operand;
      acc <= next_acc;
      file_rd <= next_file_rd;
      file_addr <= next_file_addr;
      file_we <= next_file_we;
      file_wdata <= next_file_wdata;
      zero_we <= next_zero_we;
      zero_flag <= next_zero_flag;
      done <= next_done;
      active <= next_active;
    end
  end
endmodule

// File: pkg/or_ops_pkg.sv
package or_ops_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned OPC_HI = 13;
  localparam int unsigned OPC_LO = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam logic [5:0] OPC_OR_IMM = 6'h38;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_e;
endpackage

// File: logic/or_decode.sv
`timescale 1ns/100ps
module or_decode (
  // Instruction word
  input wire logic [13:0] instr,
  // Decoded fields
  output logic is_imm,
  output logic is_file,
  output logic dest_file,
  output logic [7:0] literal,
  output logic [6:0] file_addr
);
  always_comb begin
    is_imm = instr[or_ops_pkg::OPC_HI:or_ops_pkg::OPC_LO]
      == or_ops_pkg::OPC_OR_IMM;
    is_file = instr[or_ops_pkg::OPC_HI:or_ops_pkg::OPC_LO]
      == or_ops_pkg::OPC_OR_FILE;
    dest_file = instr[or_ops_pkg::DEST_BIT];
    literal = instr[7:0];
    file_addr = instr[6:0];
  end
endmodule

// File: verification/or_ops_asserts.sv
`timescale 1ns/100ps
module or_chk (
  input wire logic clock, rst_n, instr_valid, file_rd, file_we, done,
  input wire logic zero_we, zero_flag,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata, file_wdata, acc,
  input wire logic [6:0] file_addr,
  input wire logic [1:0] phase
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_go(op);
    !phase && instr_valid && instr[13:8] == op;
  endsequence
  property p_imm;
    s_go(6'h38) |-> ##3 acc == ($past(acc, 3) | instr[7:0]);
  endproperty
  a_imm: assert property (p_imm) else $error("imm");
  property p_keep;
    s_go(6'h38) |=> !file_we [*3];
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_addr;
    s_go(6'h04) |=> file_rd && file_addr == $past(instr[6:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("addr");
  property p_d0;
    s_go(6'h04) ##0 !instr[7] |-> ##3 !file_we
      && acc == ($past(acc, 3) | $past(file_rdata, 2));
  endproperty
  a_d0: assert property (p_d0) else $error("d0");
  property p_d1;
    s_go(6'h04) ##0 instr[7] |-> ##3 file_we && $stable(acc)
      && file_wdata == (acc | $past(file_rdata, 2));
  endproperty
  a_d1: assert property (p_d1) else $error("d1");
  property p_zero;
    done |-> zero_we && zero_flag == !(file_we ? file_wdata : acc);
  endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_phase;
    1'b1 |=> phase == 2'($past(phase) + 2'h1);
  endproperty
  a_phase: assert property (p_phase) else $error("phase");
  property p_quiet;
    !phase && !(instr_valid && (instr[13:8] == 6'h38
      || instr[13:8] == 6'h04)) |=> !file_rd ##2 !done && !file_we;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
endmodule
bind inclusive_or_ops or_chk i_chk (.*);

// File: verification/file_regs.sv
`timescale 1ns/100ps
module file_regs (
  input wire logic clock, file_rd, file_we,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  // Inverse data off the read slot, so a late sample shows
  assign file_rdata = file_rd ? mem[file_addr] : ~mem[file_addr];
  always @(posedge clock) if (file_we) mem[file_addr] <= file_wdata;
endmodule

// File: verification/test_inclusive_or_ops.sv
`timescale 1ns/100ps
module test_inclusive_or_ops;
  logic clock = 0, rst_n = 0, instr_valid = 0, file_rd, file_we, done;
  logic zero_we, zero_flag;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata, file_wdata, acc, ea = 8'h00, f, r;
  logic [6:0] file_addr;
  logic ez = 1'b0;
  logic [1:0] phase;
  int err_total = 0, check_count = 0, seed = 41828, q;
  int c[3] = '{'h400, 'h580, 'h505};
  always #12.5 clock = ~clock;
  inclusive_or_ops i_dut (.*);
  file_regs i_mem (.*);
  task automatic chk(string s, logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic results;
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // q: [7:0] operand, [8] file form, [9] foreign opcode
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1;
    for (int i = 0; i < 300; i++) begin
      q = i < 3 ? c[i] : $random(seed);
      instr_valid = q[12:10] != 0;
      instr = {q[9] ? 6'h3F : q[8] ? 6'h04 : 6'h38, q[7:0]};
      f = i_mem.mem[q[6:0]];
      r = ea | (q[8] ? f : q[7:0]);
      repeat (4) @(negedge clock);
      if (instr_valid && !q[9]) begin
        ez = r == 8'h00;
        if (q[8] && q[7]) f = r;
        else ea = r;
      end
      chk("acc", ea, acc);
      chk("file", f, i_mem.mem[q[6:0]]);
      chk("zero", {7'h00, ez}, {7'h00, zero_flag});
    end
    results;
  end
endmodule
